/* logic/pic_defines.svh */
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH
// Byte addresses on the register bus
`define PIC_ADDR_ENABLE_UPPER 8'h00
`define PIC_ADDR_REQUEST_UPPER 8'h04
`define PIC_ADDR_ENABLE_LOWER 8'h08
`define PIC_ADDR_REQUEST_LOWER 8'h0c
`define PIC_ADDR_GLOBAL 8'h10
`define PIC_ADDR_VECTOR 8'h14
// Reset values
`define PIC_ENABLE_RESET 8'h00
`define PIC_REQUEST_RESET 8'h00
// Upper register bit positions
`define PIC_BIT_NMI 7
`define PIC_BIT_EXT 6
`define PIC_BIT_CAN 5
// Vector bases
`define PIC_VEC_UPPER_BASE 24'hff2030
`define PIC_VEC_LOWER_BASE 24'hff2000
// Line count and line numbers
`define PIC_LINES 16
`define PIC_LINE_CAN 13
`define PIC_LINE_NMI 15
`endif

/* logic/pic_pkg.sv */
package pic_pkg;
  typedef logic [15:0] pic_lines_t;
  typedef enum logic [1:0] {PIC_IDLE, PIC_RD, PIC_WR} pic_phase_t;
endpackage : pic_pkg

/* logic/pic_arbiter.sv */
`timescale 1ns/1ns
`include "pic_defines.svh"
module pic_arbiter
  import pic_pkg::*;
#(
  parameter int LINES = `PIC_LINES
)
(
  // Candidate requests, one per line
  input wire logic [LINES-1:0] cand,
  // Winner
  output logic found,
  output logic [3:0] line
);
  // Highest line number wins; NMI at line 15 ranks above all
  always_comb
  begin
    found = 1'b0;
    line = 4'h0;
    for (int i = 0; i < LINES; i++)
    begin
      if (cand[i])
      begin
        found = 1'b1;
        line = 4'(i); // [RULE2] [RULE14]
      end
    end
  end
endmodule : pic_arbiter

/* logic/pic_controller.sv */
`timescale 1ns/1ns
`include "pic_defines.svh"
// Behaviour
// (RULE1) Line 13 serves the CAN peripheral with own enable, pending bit and vector.
// (RULE2) Fixed priority ranking; highest level serviced first, lowest last.
// (RULE3) Vectors are fixed words: upper lines ff2030-ff203e, lower ff2000-ff200e.
// (RULE4) Shared capture, overrun, compare and timer events merge onto line zero.
// (RULE5) Software should not hand shared lines to the transaction server.
// (RULE6) A pending request is forwarded only when its enable bit is one.
// (RULE7) Global enable, set and cleared by instructions, gates all maskable lines.
// (RULE8) Upper enable is byte read/write, saved by push-all, restored by pop-all.
// (RULE9) The nonmaskable request is always honoured; its enable bit does nothing.
// (RULE10) A detected source request sets that source's pending bit.
// (RULE11) The pending bit clears when flow transfers to that source's vector.
// (RULE12) Software setting a pending bit raises the interrupt like hardware would.
// (RULE13) Upper bits 7..0: nmi, ext pin, can, rx, tx, sync1, sync0, cmd full.
// (RULE14) With several enabled pending, the highest priority vector is taken.
module pic_controller
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Upper line sources
  input wire logic nmi_request,
  input wire logic external_pin_request,
  input wire logic can_request,
  input wire logic serial_receive_request,
  input wire logic serial_transmit_request,
  input wire logic sync_serial_ch1_request,
  input wire logic sync_serial_ch0_request,
  input wire logic slave_command_full_request,
  // Lower line sources
  input wire logic slave_input_full_request,
  input wire logic slave_output_empty_request,
  input wire logic conversion_done_request,
  input wire logic capture_compare0_request,
  input wire logic capture_compare1_request,
  input wire logic capture_compare2_request,
  input wire logic capture_compare3_request,
  input wire logic [5:0] capture_compare_hi_request,
  input wire logic [9:0] capture_overrun_request,
  input wire logic [1:0] compare_only_request,
  input wire logic [1:0] timer_overflow_request,
  // Core instructions
  input wire logic enable_all_instruction,
  input wire logic disable_all_instruction,
  input wire logic push_all_instruction,
  input wire logic pop_all_instruction,
  input wire logic [7:0] pop_all_data,
  output logic [7:0] push_all_data,
  // Core vector fetch
  output logic irq_valid,
  output logic [23:0] irq_vector,
  input wire logic vector_taken
);
  pic_lines_t hw_req;
  pic_lines_t cand;
  pic_lines_t enable_all;
  logic [7:0] en_up_r, en_up_nxt, en_lo_r, en_lo_nxt;
  logic [7:0] pend_up_r, pend_up_nxt, pend_lo_r, pend_lo_nxt;
  logic glob_en_r, glob_en_nxt;
  logic [7:0] save_r, save_nxt;
  logic [23:0] vec_r, vec_nxt;
  logic valid_r, valid_nxt;
  logic [3:0] line_r, line_nxt;
  logic found;
  logic [3:0] win_line;
  pic_phase_t ph_r, ph_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic take;
  logic shared_line;

  function automatic logic [23:0] vec_of(input logic [3:0] ln);
    // Each line is one word; upper lines start at their own base
    if (ln[3])
      vec_of = `PIC_VEC_UPPER_BASE + {20'h0, ln[2:0], 1'b0}; // [RULE3]
    else
      vec_of = `PIC_VEC_LOWER_BASE + {20'h0, ln[2:0], 1'b0}; // [RULE3]
  endfunction : vec_of

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] eu, input logic [7:0] pu,
      input logic [7:0] el, input logic [7:0] pl, input logic g, input logic [23:0] v, input logic vv);
    unique case (a)
      `PIC_ADDR_ENABLE_UPPER: rd_mux = {24'h0, eu};
      `PIC_ADDR_REQUEST_UPPER: rd_mux = {24'h0, pu};
      `PIC_ADDR_ENABLE_LOWER: rd_mux = {24'h0, el};
      `PIC_ADDR_REQUEST_LOWER: rd_mux = {24'h0, pl};
      `PIC_ADDR_GLOBAL: rd_mux = {31'h0, g};
      `PIC_ADDR_VECTOR: rd_mux = {7'h0, vv, v};
      default: rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  assign shared_line = |capture_compare_hi_request | |capture_overrun_request
      | |compare_only_request | |timer_overflow_request; // [RULE4]
  assign hw_req = {nmi_request, external_pin_request, can_request, serial_receive_request, // [RULE1] [RULE13]
      serial_transmit_request, sync_serial_ch1_request, sync_serial_ch0_request, slave_command_full_request,
      slave_input_full_request, slave_output_empty_request, conversion_done_request, capture_compare0_request,
      capture_compare1_request, capture_compare2_request, capture_compare3_request, shared_line};
  // Maskable lines need their enable and the global enable; NMI needs neither
  always_comb
  begin
    enable_all = {en_up_r, en_lo_r} & {16{glob_en_r}}; // [RULE6] [RULE7]
    enable_all[`PIC_LINE_NMI] = 1'b1; // [RULE9]
    cand = {pend_up_r, pend_lo_r} & enable_all;
  end

  pic_arbiter #(.LINES(`PIC_LINES)) u_arb (
    .cand(cand),
    .found(found),
    .line(win_line)
  );

  assign take = valid_r && vector_taken;

  // Bus slave: zero wait states, OKAY always
  always_comb
  begin
    ph_nxt = PIC_IDLE;
    addr_nxt = addr_r;
    if (hsel && hready && htrans[1])
    begin
      ph_nxt = hwrite ? PIC_WR : PIC_RD;
      addr_nxt = haddr;
    end
    rdata_nxt = rdata_r;
    if (hsel && hready && htrans[1] && !hwrite)
      rdata_nxt = rd_mux(haddr, en_up_r, pend_up_r, en_lo_r, pend_lo_r, glob_en_r, vec_r, valid_r);
  end

  // Register file, pending capture and vector handoff
  always_comb
  begin
    en_up_nxt = en_up_r;
    en_lo_nxt = en_lo_r;
    pend_up_nxt = pend_up_r;
    pend_lo_nxt = pend_lo_r;
    glob_en_nxt = glob_en_r;
    save_nxt = save_r;
    if (ph_r == PIC_WR)
    begin
      unique case (addr_r)
        `PIC_ADDR_ENABLE_UPPER: en_up_nxt = hwdata[7:0]; // [RULE8]
        `PIC_ADDR_ENABLE_LOWER: en_lo_nxt = hwdata[7:0];
        `PIC_ADDR_REQUEST_UPPER: pend_up_nxt = hwdata[7:0]; // [RULE12]
        `PIC_ADDR_REQUEST_LOWER: pend_lo_nxt = hwdata[7:0]; // [RULE12]
        `PIC_ADDR_GLOBAL: glob_en_nxt = hwdata[0];
        default: ;
      endcase
    end
    if (push_all_instruction)
      save_nxt = en_up_r; // [RULE8]
    if (pop_all_instruction)
      en_up_nxt = pop_all_data; // [RULE8]
    if (enable_all_instruction)
      glob_en_nxt = 1'b1; // [RULE7]
    if (disable_all_instruction)
      glob_en_nxt = 1'b0; // [RULE7]
    if (take)
    begin
      if (line_r[3])
        pend_up_nxt[line_r[2:0]] = 1'b0; // [RULE11]
      else
        pend_lo_nxt[line_r[2:0]] = 1'b0; // [RULE11]
    end
    // New events win over any clear in the same cycle
    pend_up_nxt = pend_up_nxt | hw_req[15:8]; // [RULE10]
    pend_lo_nxt = pend_lo_nxt | hw_req[7:0]; // [RULE10]
    valid_nxt = found && !take;
    line_nxt = win_line;
    vec_nxt = vec_of(win_line); // [RULE14]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_up_r <= `PIC_ENABLE_RESET;
      en_lo_r <= `PIC_ENABLE_RESET;
      pend_up_r <= `PIC_REQUEST_RESET;
      pend_lo_r <= `PIC_REQUEST_RESET;
      glob_en_r <= 1'b0;
      save_r <= `PIC_ENABLE_RESET;
      vec_r <= 24'h0;
      valid_r <= 1'b0;
      line_r <= 4'h0;
      ph_r <= PIC_IDLE;
      addr_r <= 8'h0;
      rdata_r <= 32'h0;
    end
    else
    begin
      en_up_r <= en_up_nxt;
      en_lo_r <= en_lo_nxt;
      pend_up_r <= pend_up_nxt;
      pend_lo_r <= pend_lo_nxt;
      glob_en_r <= glob_en_nxt;
      save_r <= save_nxt;
      vec_r <= vec_nxt;
      valid_r <= valid_nxt;
      line_r <= line_nxt;
      ph_r <= ph_nxt;
      addr_r <= addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign hrdata = rdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign push_all_data = save_r;
  assign irq_valid = valid_r;
  assign irq_vector = vec_r;

  chk_nmi_unmasked: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
    pend_up_r[`PIC_BIT_NMI] && !take |=> valid_r && line_r == 4'(`PIC_LINE_NMI))
    else $error("nmi pending but not offered");
  chk_mask_blocks: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE6]
    valid_r && line_r != 4'(`PIC_LINE_NMI) |-> |($past({en_up_r, en_lo_r}) & (16'h0001 << line_r)))
    else $error("masked line offered");
  chk_global_gate: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
    valid_r && !$past(glob_en_r) |-> line_r == 4'(`PIC_LINE_NMI))
    else $error("maskable offered while globally disabled");
  chk_vector_map: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
    valid_r |-> irq_vector == `PIC_VEC_LOWER_BASE + {19'h0, line_r, 1'b0} + {18'h0, line_r[3], 5'h0})
    else $error("vector does not match line");
  chk_can_vector: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
    valid_r && line_r == 4'(`PIC_LINE_CAN) |-> irq_vector == 24'hff203a)
    else $error("can vector wrong");
  chk_pend_set: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
    can_request |=> pend_up_r[`PIC_BIT_CAN])
    else $error("request not latched");
  chk_ext_set: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
    external_pin_request |=> pend_up_r[`PIC_BIT_EXT])
    else $error("external request not latched");
  chk_take_clear: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
    take && line_r[3] && !hw_req[line_r] && ph_r != PIC_WR |=> !pend_up_r[$past(line_r[2:0])])
    else $error("pending not cleared on take");
  chk_priority: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
    found |-> (cand >> win_line) == 16'h1)
    else $error("lower priority won");
  chk_shared_line: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
    |timer_overflow_request |=> pend_lo_r[0])
    else $error("shared line not set");
  chk_pop_all_instruction_restore: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
    pop_all_instruction |=> en_up_r == $past(pop_all_data))
    else $error("pop-all restore failed");
  chk_sw_set: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
    ph_r == PIC_WR && addr_r == `PIC_ADDR_REQUEST_UPPER && hwdata[1] && !take |=> pend_up_r[1])
    else $error("software set lost");
  cov_nmi: cover property (@(posedge hclk) take && line_r == 4'hf);
  cov_can: cover property (@(posedge hclk) take && line_r == 4'hd);
  cov_shared: cover property (@(posedge hclk) take && line_r == 4'h0);
  cov_two: cover property (@(posedge hclk) $countones(cand) > 1);
endmodule : pic_controller

/* tb/pic_core_model.sv */
`timescale 1ns/1ns
module pic_core_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Vector fetch
  input wire logic irq_valid,
  input wire logic [23:0] irq_vector,
  output logic vector_taken,
  // Control and record
  input wire logic take_en,
  input wire logic [3:0] delay,
  output logic [23:0] last_vector,
  output logic [7:0] take_count
);
  logic [3:0] wait_r;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vector_taken <= 1'b0;
      wait_r <= 4'h0;
      last_vector <= 24'h000000;
      take_count <= 8'h00;
    end
    // A cycle off after each take keeps takes two cycles apart
    else if (vector_taken)
    begin
      vector_taken <= 1'b0;
      wait_r <= 4'h0;
    end
    // Every line, the shared one too, is served here by its vector, never by a transaction server
    else if (take_en && irq_valid === 1'b1)
    begin
      if (wait_r == delay)
      begin
        vector_taken <= 1'b1;
        last_vector <= irq_vector;
        take_count <= take_count + 8'h01;
      end
      else
        wait_r <= wait_r + 4'h1;
    end
    else
      wait_r <= 4'h0;
  end
endmodule : pic_core_model

/* tb/pic_controller_tb_top.sv */
`timescale 1ns/1ns
module pic_controller_tb_top;
  import pic_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hreadyout, hresp, irq_valid, vector_taken;
  logic take_en = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [38:0] src = 39'h0;
  logic [7:0] pop_data = 8'h00;
  logic [7:0] push_data, take_count;
  logic [23:0] irq_vector, last_vector;
  int fails = 0;
  int comparisons = 0;
  always #5 hclk = ~hclk;
  pic_controller u_pic_controller (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nmi_request(src[7]), .external_pin_request(src[6]), .can_request(src[5]),
    .serial_receive_request(src[4]), .serial_transmit_request(src[3]),
    .sync_serial_ch1_request(src[2]), .sync_serial_ch0_request(src[1]),
    .slave_command_full_request(src[0]), .slave_input_full_request(src[34]),
    .slave_output_empty_request(src[33]), .conversion_done_request(src[32]),
    .capture_compare0_request(src[31]), .capture_compare1_request(src[30]),
    .capture_compare2_request(src[29]), .capture_compare3_request(src[28]),
    .capture_compare_hi_request(src[27:22]), .capture_overrun_request(src[21:12]),
    .compare_only_request(src[11:10]), .timer_overflow_request(src[9:8]),
    .enable_all_instruction(src[35]), .disable_all_instruction(src[36]),
    .push_all_instruction(src[37]), .pop_all_instruction(src[38]), .pop_all_data(pop_data),
    .push_all_data(push_data), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .vector_taken(vector_taken));
  pic_core_model u_pic_core_model (.hclk(hclk), .hresetn(hresetn), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .vector_taken(vector_taken), .take_en(take_en), .delay(dly),
    .last_vector(last_vector), .take_count(take_count));
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task wait_ready;
    int n;
    n = 0;
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        fails++;
        finish_test;
      end
      @(posedge hclk);
    end
  endtask : wait_ready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    wait_ready;
    q = hrdata;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask : rd
  task pulse(input int i);
    src[i] <= 1'b1;
    @(posedge hclk);
    src <= 39'h0;
    @(posedge hclk);
  endtask : pulse
  task take(input logic [23:0] v);
    int n;
    logic [7:0] c;
    c = take_count;
    n = 0;
    take_en <= 1'b1;
    while (take_count === c)
    begin
      n++;
      if (n > 100)
      begin
        fails++;
        finish_test;
      end
      @(posedge hclk);
    end
    take_en <= 1'b0;
    // Let an edge pass so a following take does not raise take_en in this time step
    @(posedge hclk);
    chk({8'h00, last_vector}, {8'h00, v});
  endtask : take
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h1c, 32'h0);
    bus(1'b1, 8'h00, 32'h25);
    rd(8'h00, 32'h25);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      pulse(i);
      rd(8'h04, 32'h1 << i);
      bus(1'b1, 8'h04, 32'h0);
    end
    for (int i = 8; i < 35; i++)
    begin
      pulse(i);
      rd(8'h0c, (i < 28) ? 32'h1 : 32'h1 << (i - 27));
      bus(1'b1, 8'h0c, 32'h0);
    end
    $display("test pending done");
    bus(1'b1, 8'h00, 32'h0);
    pulse(35);
    rd(8'h10, 32'h1);
    pulse(5);
    repeat (3) @(posedge hclk);
    chk(irq_valid, 1'b0);
    pulse(36);
    bus(1'b1, 8'h00, 32'h20);
    repeat (3) @(posedge hclk);
    chk(irq_valid, 1'b0);
    pulse(35);
    dly <= 4'h3;
    take(24'hff203a);
    rd(8'h04, 32'h0);
    dly <= 4'h0;
    bus(1'b1, 8'h00, 32'h06);
    bus(1'b1, 8'h04, 32'h06);
    take(24'hff2034);
    take(24'hff2032);
    pulse(36);
    bus(1'b1, 8'h00, 32'h0);
    pulse(7);
    take(24'hff203e);
    bus(1'b1, 8'h08, 32'h81);
    rd(8'h08, 32'h81);
    pulse(35);
    pulse(8);
    pulse(34);
    rd(8'h14, 32'h01ff200e);
    take(24'hff200e);
    take(24'hff2000);
    $display("test vectors done");
    bus(1'b1, 8'h00, 32'h5a);
    pulse(37);
    chk(push_data, 8'h5a);
    pop_data <= 8'h3c;
    pulse(38);
    rd(8'h00, 32'h3c);
    bus(1'b1, 8'h10, 32'h0);
    rd(8'h10, 32'h0);
    $display("test push pop done");
    finish_test;
  end
endmodule : pic_controller_tb_top
